// ===== acc_defines.svh
// offsets, field positions, reset values and timing counts for the
// comparator control block; included by the top module only
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
`define ACC_OFS_CTRL1 12'h000
`define ACC_OFS_CTRL2 12'h004
`define ACC_OFS_AUX 12'h008
`define ACC_OFS_FLAGS 12'h00c
`define ACC_BIT_ON 7
`define ACC_BIT_RESULT 6
`define ACC_BIT_OE 5
`define ACC_BIT_POL 4
`define ACC_BIT_SP 3
`define ACC_BIT_REF 2
`define ACC_CTRL_RST 8'h08
`define ACC_CTRL_WMASK 8'hbf
`define ACC_AUX_RST 8'h00
`define ACC_AUX_WMASK 8'h03
`define ACC_PHASES 2'h3
`define ACC_PH_ONE 2'h0
`define ACC_PH_THREE 2'h2
`endif

// ===== acc_pkg.sv
// types of the comparator control block
// uses nothing from acc_defines.svh; field order matches its bit positions
package acc_pkg;
   typedef struct packed
   {
      logic on;
      logic result;
      logic pinEnable;
      logic polarity;
      logic speedPower;
      logic refSelect;
      logic [1:0] invSelect;
   } acc_ctrl_t;
   typedef struct packed
   {
      logic [5:0] unused;
      logic syncSelect1;
      logic syncSelect2;
   } acc_aux_t;
   typedef struct packed
   {
      logic first;
      logic second;
      logic mismatch;
   } acc_chg_t;
endpackage

// ===== acc_change_detect.sv
// mismatch latch pair of one comparator
// assumes phase strobes come from the top's four-phase divider
`timescale 1ns/1ns
`default_nettype none
module acc_change_detect
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // phase strobes and access
   input wire logic phaseOne,
   input wire logic phaseThree,
   input wire logic sleep,
   input wire logic regAccess,
   input wire logic compOut,
   // event
   output logic changePulse
);
   import acc_pkg::*;
   acc_chg_t state;
   acc_chg_t next_state;
   logic xorNow;
   always_comb
   begin
      next_state = state;
      // in sleep phase one stays high so the second latch is transparent
      if (phaseOne || sleep)
         next_state.second = compOut;
      if (phaseThree && regAccess)
         next_state.first = compOut;
      xorNow = next_state.first ^ next_state.second;
      next_state.mismatch = xorNow;
      changePulse = xorNow && !state.mismatch;
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         state <= '0;
      else
         state <= next_state;
   end
endmodule
`default_nettype wire

// ===== acc_top.sv
// two-comparator control: registers over APB, output path, change flags
// assumes analog results arrive as synchronous levels; pads resolve pins
//
// How it works
// - result high when noninverting input above inverting, low when below
// - first comparator presents zero to change detect while off
// - latches clocked on phase one and phase three of four phases
// - in sleep phase one held high so second latch stays transparent
// - one control register per comparator plus an auxiliary register
// - control holds enable, input, reference, pin, polarity, speed
// - on bit set runs comparator; clear means off, lowest current
// - two-bit select routes one of four inverting input pins
// - polarity bit set inverts output, clear passes it
// - access latch at phase three, phase-one latch, mismatch sets flag
// - pin driven only when pin enable, direction clear and on set
// - reset returns control registers to reset values, all off
//
// Our own choices: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "acc_defines.svh"
module acc_top
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // analog side
   input wire logic [1:0] rawCompare,
   input wire logic sleep,
   input wire logic timerTick,
   input wire logic [1:0] pinDirection,
   // analog controls
   output logic [1:0] compEnable,
   output logic [1:0] speedPowerSelect,
   output logic [1:0] referenceSelect,
   output logic [3:0] invertingInputSelect,
   // outputs
   output logic [1:0] compPinOut,
   output logic [1:0] compPinOe,
   output logic [1:0] pwmShutdown,
   output logic [1:0] syncOut
);
   import acc_pkg::*;
   typedef struct packed
   {
      acc_ctrl_t [1:0] ctrl;
      acc_aux_t aux;
      logic [1:0] changeFlag;
      logic [1:0] phase;
      logic [1:0] syncRes;
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic [1:0] pinOut;
      logic [1:0] pinOe;
      logic [1:0] pwm;
      logic [1:0] sout;
   } acc_state_t;
   acc_state_t s;
   acc_state_t next_s;
   logic [1:0] polOut;
   logic [1:0] detectIn;
   logic [1:0] access;
   logic [1:0] change;
   logic phOne;
   logic phThree;
   logic accessNow;
   logic wrNow;
   assign phOne = (s.phase == `ACC_PH_ONE);
   assign phThree = (s.phase == `ACC_PH_THREE);
   assign accessNow = psel && penable && !s.ready;
   assign wrNow = accessNow && pwrite;
   genvar g;
   generate
      for (g = 0; g < 2; g++)
      begin : gComp
         // off comparator: polarity alone sets the level, for presetting
         assign polOut[g] = (rawCompare[g] & s.ctrl[g].on)
            ^ s.ctrl[g].polarity;
         // first comparator feeds zero while off, second follows polarity
         if (g == 0)
         begin : gFirst
            assign detectIn[g] = polOut[g] & s.ctrl[g].on;
         end
         else
         begin : gSecond
            assign detectIn[g] = polOut[g];
         end
         assign access[g] = accessNow
            && (paddr == (g == 0 ? `ACC_OFS_CTRL1 : `ACC_OFS_CTRL2));
         acc_change_detect uDetect
         (
            .clk(clk),
            .rst_n(rst_n),
            .phaseOne(phOne),
            .phaseThree(phThree),
            .sleep(sleep),
            .regAccess(access[g]),
            .compOut(detectIn[g]),
            .changePulse(change[g])
         );
      end
   endgenerate
   always_comb
   begin
      next_s = s;
      next_s.phase = s.phase + 2'h1;
      next_s.ready = accessNow;
      next_s.err = 1'b0;
      for (int i = 0; i < 2; i++)
      begin
         // rawCompare is the analog decision: high when + above
         next_s.ctrl[i].result = polOut[i];
         if (timerTick)
            next_s.syncRes[i] = polOut[i];
         next_s.sout[i] = (i == 0 ? s.aux.syncSelect1 : s.aux.syncSelect2)
            ? s.syncRes[i] : polOut[i];
         next_s.pwm[i] = polOut[i];
         next_s.pinOut[i] = polOut[i];
         next_s.pinOe[i] = s.ctrl[i].pinEnable && !pinDirection[i]
            && s.ctrl[i].on;
         // set wins over a software clear in the same cycle
         if (change[i])
            next_s.changeFlag[i] = 1'b1;
      end
      if (accessNow)
      begin
         next_s.rdata = '0;
         unique case (paddr)
            `ACC_OFS_CTRL1, `ACC_OFS_CTRL2:
            begin
               next_s.rdata[7:0] = s.ctrl[paddr[2]];
               if (pwrite)
                  next_s.ctrl[paddr[2]] = acc_ctrl_t'(
                     (pwdata[7:0] & `ACC_CTRL_WMASK)
                     | ({7'h00, polOut[paddr[2]]} << `ACC_BIT_RESULT));
            end
            `ACC_OFS_AUX:
            begin
               next_s.rdata[7:0] = {polOut, 4'h0, s.aux.syncSelect1,
                  s.aux.syncSelect2};
               if (pwrite)
                  next_s.aux = acc_aux_t'(pwdata[7:0] & `ACC_AUX_WMASK);
            end
            `ACC_OFS_FLAGS:
            begin
               next_s.rdata[1:0] = s.changeFlag;
               // write one to clear; a same-cycle event keeps the flag set
               if (pwrite)
                  next_s.changeFlag = (s.changeFlag & ~pwdata[1:0]) | change;
            end
            default:
               next_s.err = 1'b1;
         endcase
      end
   end
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s <= '0;
         s.ctrl[0] <= acc_ctrl_t'(`ACC_CTRL_RST);
         s.ctrl[1] <= acc_ctrl_t'(`ACC_CTRL_RST);
         s.aux <= acc_aux_t'(`ACC_AUX_RST);
      end
      else
         s <= next_s;
   end
   // analog controls straight from the control flops
   assign compEnable = {s.ctrl[1].on, s.ctrl[0].on};
   assign speedPowerSelect = {s.ctrl[1].speedPower, s.ctrl[0].speedPower};
   assign referenceSelect = {s.ctrl[1].refSelect, s.ctrl[0].refSelect};
   assign invertingInputSelect = {s.ctrl[1].invSelect, s.ctrl[0].invSelect};
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.err;
   assign compPinOut = s.pinOut;
   assign compPinOe = s.pinOe;
   assign pwmShutdown = s.pwm;
   assign syncOut = s.sout;
endmodule
`default_nettype wire

// ===== acc_analog_model.sv
// analog pins and references seen by the comparators
// assumes voltages come from the bench as 8-bit levels
`timescale 1ns/1ns
`default_nettype none
module acc_analog_model
(
   // selection from the block
   input wire logic [3:0] invertingInputSelect,
   // levels set by the bench
   input wire logic [15:0] plusLevel,
   input wire logic [31:0] pinLevel,
   // decisions to the block
   output logic [1:0] rawCompare
);
   // ties never happen here, so no hysteresis is modelled
   // pads are analog inputs with their drivers off, levels only
   assign rawCompare[0] = plusLevel[7:0] >
      pinLevel[8*invertingInputSelect[1:0] +: 8];
   assign rawCompare[1] = plusLevel[15:8] >
      pinLevel[8*invertingInputSelect[3:2] +: 8];
endmodule
`default_nettype wire

// ===== acc_top_assertions.sv
// port checks of the comparator control block
// assumes it is bound to acc_top and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module acc_top_checker
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // controls
   input wire logic [1:0] pinDirection,
   input wire logic [1:0] compEnable,
   input wire logic [1:0] speedPowerSelect,
   input wire logic [1:0] referenceSelect,
   input wire logic [3:0] invertingInputSelect,
   input wire logic [1:0] compPinOe
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   a_ready_after_setup: assert property (psel && !penable |-> ##2 pready)
      else $error("no ready after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   a_err_reads_zero: assert property (pslverr |-> pready && prdata == 0)
      else $error("error without ready or with data");
   a_err_unmapped: assert property (pready |-> pslverr == (paddr > 12'h00c))
      else $error("error flag wrong for address");
   a_read_low_byte: assert property (pready && !pwrite |-> prdata[31:8] == 0)
      else $error("upper read bits set");
   a_ctrl_by_write: assert property ($changed({compEnable, speedPowerSelect,
      referenceSelect, invertingInputSelect}) |-> pready && pwrite)
      else $error("control moved without write");
   a_pin_drive_gate: assert property ((compPinOe &
      ~$past(compEnable & ~pinDirection)) == 2'h0)
      else $error("pin driven while off or input");
   a_reset_values: assert property ($rose(rst_n) |-> compEnable == 2'h0 &&
      speedPowerSelect == 2'h3 && compPinOe == 2'h0)
      else $error("outputs not at reset values");
endmodule
`default_nettype wire

// ===== test_acc_top.sv
// self-checking bench of the comparator control block
// assumes acc_top, the analog model and the checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin \
   bad_count++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module test_acc_top;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
   logic sleep = 0, timerTick = 0, err;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, pinLevel = 32'hf0f0f0f0;
   logic [1:0] rawCompare, compEnable, compPinOut, compPinOe;
   logic [1:0] pinDirection = 0;
   logic [1:0] speedPowerSelect, referenceSelect, pwmShutdown, syncOut;
   logic tickRun = 1;
   logic [3:0] invertingInputSelect;
   logic pready, pslverr;
   int bad_count = 0, samples_checked = 0;
   acc_top u_acc_top (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rawCompare(rawCompare), .sleep(sleep), .timerTick(timerTick),
      .pinDirection(pinDirection), .compEnable(compEnable),
      .speedPowerSelect(speedPowerSelect), .referenceSelect(referenceSelect),
      .invertingInputSelect(invertingInputSelect), .compPinOut(compPinOut),
      .compPinOe(compPinOe), .pwmShutdown(pwmShutdown), .syncOut(syncOut));
   acc_analog_model u_acc_analog_model (.plusLevel(16'h8080),
      .invertingInputSelect(invertingInputSelect), .pinLevel(pinLevel),
      .rawCompare(rawCompare));
   always #2 clk = ~clk;
   // a running tick keeps the resync path busy
   // internal timer enable only, never gated by the synced output
   always @(posedge clk) timerTick <= tickRun && !timerTick;
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge clk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      apb(0, a, 0);
      `CHK("prdata", e, rd)
   endtask
   task automatic tog();
      pinLevel <= ~pinLevel;
      repeat (6) @(posedge clk);
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      #20000;
      bad_count++;
      results();
   end
   initial
   begin
      repeat (3) @(posedge clk);
      rst_n <= 1;
      rdchk(0, 8);
      rdchk(4, 8);
      rdchk(8, 0);
      `CHK("speedPowerSelect", 2'h3, speedPowerSelect)
      rdchk(12'h010, 0);
      `CHK("pslverr", 1'b1, err)
      $display("reset test done");
      for (int k = 0; k < 4; k++)
      begin
         pinLevel <= 32'hf0f0f0f0 & ~(32'he0 << (8 * k));
         apb(1, 0, 32'h88 | k);
         apb(1, 4, 32'h88 | k);
         repeat (6) @(posedge clk);
         `CHK("select", {k[1:0], k[1:0]}, invertingInputSelect)
         rdchk(0, 32'hc8 | k);
         rdchk(8, 32'hc0);
      end
      $display("select test done");
      pinLevel <= 32'h10101010;
      apb(1, 0, 32'h98);
      rdchk(0, 32'h98);
      apb(1, 0, 32'h18);
      rdchk(0, 32'h58);
      `CHK("compEnable", 2'h2, compEnable)
      apb(1, 0, 32'ha8);
      repeat (4) @(posedge clk);
      `CHK("pin", 2'h3, {compPinOe[0], compPinOut[0]})
      pinDirection <= 2'h1;
      repeat (4) @(posedge clk);
      `CHK("compPinOe", 1'b0, compPinOe[0])
      $display("output test done");
      apb(1, 4, 32'h84);
      apb(1, 8, 32'h2);
      repeat (2) @(posedge clk);
      `CHK("speedPowerSelect", 2'h1, speedPowerSelect)
      `CHK("referenceSelect", 2'h2, referenceSelect)
      `CHK("pwmShutdown", 2'h3, pwmShutdown)
      tickRun <= 0;
      repeat (2) @(posedge clk);
      pinLevel <= ~pinLevel;
      repeat (4) @(posedge clk);
      `CHK("syncOut", 2'h1, syncOut)
      `CHK("pwmShutdown", 2'h0, pwmShutdown)
      tickRun <= 1;
      repeat (4) @(posedge clk);
      `CHK("syncOut", 2'h0, syncOut)
      pinLevel <= ~pinLevel;
      $display("sync test done");
      apb(1, 0, 32'h08);
      apb(1, 4, 32'h08);
      // let both latch pairs settle so no late edge beats the clear
      repeat (8) @(posedge clk);
      apb(1, 12, 32'h3);
      tog();
      tog();
      rdchk(12, 0);
      sleep <= 1;
      apb(1, 0, 32'h88);
      tog();
      tog();
      apb(0, 12, 0);
      `CHK("flags", 2'h1, rd[1:0])
      sleep <= 0;
      apb(1, 12, 32'h3);
      rdchk(12, 0);
      $display("change test done");
      results();
   end
endmodule
bind acc_top acc_top_checker u_acc_top_checker (.clk(clk), .rst_n(rst_n),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pinDirection(pinDirection), .compEnable(compEnable),
   .speedPowerSelect(speedPowerSelect), .referenceSelect(referenceSelect),
   .invertingInputSelect(invertingInputSelect), .compPinOe(compPinOe));
`default_nettype wire
